// ### rtl/fwd_watchdog.v
// Fieldbus watchdog: trigger, countdown, status and stop registers
`timescale 1ns/1ns
`include "fwd_map.vh"

module fwd_watchdog #(
  parameter TICK_CYCLES = `FWD_TICK_CYCLES,
  parameter TICK_W = 21
) (
  input wire sys_clk,
  input wire nrst,
  input wire clk_en,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire req_valid,
  input wire [7:0] req_code,
  output wire [15:0] rd_data,
  output wire rd_ack,
  output wire run_state,
  output wire wd_expired,
  output wire wd_fault
);

  localparam [31:0] TICK_L32 = TICK_CYCLES - 1;
  localparam [TICK_W-1:0] TICK_LAST = TICK_L32[TICK_W-1:0];
  localparam [TICK_W-1:0] PRESC_ONE = {{(TICK_W-1){1'b0}}, 1'b1};
  localparam [13:0] STATUS_PAD = 14'h0000;

  reg [15:0] timeout_q;
  reg [15:0] mask_lo_q;
  reg [15:0] mask_hi_q;
  reg [15:0] trigger_q;
  reg [15:0] min_rem_q;
  reg [15:0] stop_seq_q;
  reg [15:0] restart_q;
  reg [15:0] simple_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] remain_q;
  reg [15:0] remain_d;
  reg [TICK_W-1:0] presc_q;
  reg [TICK_W-1:0] presc_d;
  reg armed_q;
  reg fault_q;
  reg fault_d;
  reg [15:0] rd_data_q;
  reg rd_ack_q;
  reg [15:0] min_rem_d;
  reg running_q;
  reg expired_q;

  // Write strobe for one register address
  function wr_hit;
    input wr;
    input [15:0] addr;
    input [15:0] want;
    begin
      wr_hit = wr && (addr == want);
    end
  endfunction

  // Mask bit for a function code; bit 0 is code 1
  function code_hit;
    input [7:0] code;
    input [31:0] mask;
    reg [7:0] idx;
    begin
      idx = code - 8'h01;
      code_hit = (code != 8'h00) && (code <= `FWD_CODE_MAX) && mask[idx[4:0]];
    end
  endfunction

  // Status word for the read port
  function [15:0] status_word;
    input [1:0] st;
    begin
      status_word = {STATUS_PAD, st};
    end
  endfunction

  wire wr_timeout = wr_hit(reg_wr, reg_addr, `FWD_ADDR_TIMEOUT);
  wire wr_mask_lo = wr_hit(reg_wr, reg_addr, `FWD_ADDR_MASK_LO);
  wire wr_mask_hi = wr_hit(reg_wr, reg_addr, `FWD_ADDR_MASK_HI);
  wire wr_trigger = wr_hit(reg_wr, reg_addr, `FWD_ADDR_TRIGGER);
  wire wr_min_rem = wr_hit(reg_wr, reg_addr, `FWD_ADDR_MIN_REM);
  wire wr_stop_seq = wr_hit(reg_wr, reg_addr, `FWD_ADDR_STOP_SEQ);
  wire wr_restart = wr_hit(reg_wr, reg_addr, `FWD_ADDR_RESTART);
  wire wr_simple = wr_hit(reg_wr, reg_addr, `FWD_ADDR_SIMPLE_STOP);

  // Configuration is locked in any state but inactive
  wire cfg_open = (state_q == `FWD_STATE_IDLE);

  // Locked writes are dropped silently, no error path
  wire cfg_wr_timeout = wr_timeout && cfg_open;
  wire cfg_wr_mask_lo = wr_mask_lo && cfg_open;
  wire cfg_wr_mask_hi = wr_mask_hi && cfg_open;

  // Only a running watchdog counts down or takes request reloads
  wire running_now = (state_q == `FWD_STATE_RUN);

  wire trig_fire = wr_trigger
    && ((reg_wdata != 16'h0000) || (reg_wdata != trigger_q));

  wire restart_fire = wr_restart && (reg_wdata == `FWD_RESTART_CMD)
    && (state_q != `FWD_STATE_IDLE);

  wire code_fire = req_valid && running_now
    && code_hit(req_code, {mask_hi_q, mask_lo_q});

  wire reload = (trig_fire || restart_fire || code_fire)
    && (timeout_q != 16'h0000);

  // Either byte order of the stop word is accepted
  wire simple_word = (reg_wdata == `FWD_SIMPLE_A) || (reg_wdata == `FWD_SIMPLE_B);

  wire simple_stop = wr_simple && simple_word;

  wire seq_stop = wr_stop_seq && armed_q
    && (reg_wdata == `FWD_STOP_SECOND);

  wire tick = running_now && (presc_q == TICK_LAST);

  // Countdown and state; stops outrank reloads, reloads outrank the tick
  always @* begin
    state_d = state_q;
    remain_d = remain_q;
    presc_d = presc_q;
    fault_d = fault_q;
    if (simple_stop) begin
      state_d = `FWD_STATE_IDLE;
      presc_d = {TICK_W{1'b0}};
      fault_d = 1'b0;
    end else if (seq_stop) begin
      state_d = `FWD_STATE_IDLE;
      presc_d = {TICK_W{1'b0}};
    end else if (reload) begin
      state_d = `FWD_STATE_RUN;
      remain_d = timeout_q;
      presc_d = {TICK_W{1'b0}};
    end else if (state_q == `FWD_STATE_RUN) begin
      if (tick) begin
        presc_d = {TICK_W{1'b0}};
        remain_d = remain_q - 16'h0001;
        if (remain_q == 16'h0001) begin
          state_d = `FWD_STATE_EXP;
          fault_d = 1'b1;
        end
      end else begin
        presc_d = presc_q + PRESC_ONE;
      end
    end
  end

  // Shortest remaining time tracking
  always @* begin
    min_rem_d = min_rem_q;
    if (simple_stop) begin
      min_rem_d = `FWD_RST_MIN_REM;
    end else if (wr_min_rem) begin
      min_rem_d = reg_wdata;
    end else if (state_q != `FWD_STATE_IDLE) begin
      if (remain_q < min_rem_q) begin
        min_rem_d = remain_q;
      end
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= `FWD_STATE_IDLE;
      remain_q <= 16'h0000;
      presc_q <= {TICK_W{1'b0}};
      fault_q <= 1'b0;
      min_rem_q <= `FWD_RST_MIN_REM;
    end else if (clk_en) begin
      state_q <= state_d;
      remain_q <= remain_d;
      presc_q <= presc_d;
      fault_q <= fault_d;
      min_rem_q <= min_rem_d;
    end
  end

  // Register storage
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      timeout_q <= `FWD_RST_TIMEOUT;
      mask_lo_q <= `FWD_RST_MASK;
      mask_hi_q <= `FWD_RST_MASK;
      trigger_q <= `FWD_RST_TRIGGER;
      stop_seq_q <= `FWD_RST_STOP_SEQ;
      restart_q <= `FWD_RST_RESTART;
      simple_q <= `FWD_RST_SIMPLE_STOP;
      armed_q <= 1'b0;
    end else if (clk_en) begin
      if (cfg_wr_timeout) begin
        timeout_q <= reg_wdata;
      end
      if (cfg_wr_mask_lo) begin
        mask_lo_q <= reg_wdata;
      end
      if (cfg_wr_mask_hi) begin
        mask_hi_q <= reg_wdata;
      end
      if (wr_trigger) begin
        trigger_q <= reg_wdata;
      end
      if (wr_restart) begin
        restart_q <= reg_wdata;
      end
      if (wr_simple) begin
        simple_q <= reg_wdata;
      end
      // Any stop-sequence register write other than the first half disarms the sequence
      if (wr_stop_seq) begin
        stop_seq_q <= reg_wdata;
        armed_q <= (reg_wdata == `FWD_STOP_FIRST);
      end
    end
  end

  // Read port, one cycle latency; unmapped words read zero
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 16'h0000;
      rd_ack_q <= 1'b0;
    end else if (clk_en) begin
      rd_ack_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `FWD_ADDR_TIMEOUT: begin
            rd_data_q <= timeout_q;
          end
          `FWD_ADDR_MASK_LO: begin
            rd_data_q <= mask_lo_q;
          end
          `FWD_ADDR_MASK_HI: begin
            rd_data_q <= mask_hi_q;
          end
          `FWD_ADDR_TRIGGER: begin
            rd_data_q <= trigger_q;
          end
          `FWD_ADDR_MIN_REM: begin
            rd_data_q <= min_rem_q;
          end
          `FWD_ADDR_STOP_SEQ: begin
            rd_data_q <= stop_seq_q;
          end
          `FWD_ADDR_RUN_STATE: begin
            rd_data_q <= status_word(state_q);
          end
          `FWD_ADDR_RESTART: begin
            rd_data_q <= restart_q;
          end
          `FWD_ADDR_SIMPLE_STOP: begin
            rd_data_q <= simple_q;
          end
          default: begin
            rd_data_q <= 16'h0000;
          end
        endcase
      end
    end
  end

  // Status outputs from flops fed by the next state, so they track state_q
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      running_q <= 1'b0;
      expired_q <= 1'b0;
    end else if (clk_en) begin
      running_q <= (state_d == `FWD_STATE_RUN);
      expired_q <= (state_d == `FWD_STATE_EXP);
    end
  end

  assign rd_data = rd_data_q;
  assign rd_ack = rd_ack_q;
  assign run_state = running_q;
  assign wd_expired = expired_q;
  assign wd_fault = fault_q;

endmodule

// ### rtl/fwd_map.vh
// Register offsets, field values and timing constants of the fieldbus watchdog
`ifndef FWD_MAP_VH
`define FWD_MAP_VH

`define FWD_ADDR_TIMEOUT 16'h1000
`define FWD_ADDR_MASK_LO 16'h1001
`define FWD_ADDR_MASK_HI 16'h1002
`define FWD_ADDR_TRIGGER 16'h1003
`define FWD_ADDR_MIN_REM 16'h1004
`define FWD_ADDR_STOP_SEQ 16'h1005
`define FWD_ADDR_RUN_STATE 16'h1006
`define FWD_ADDR_RESTART 16'h1007
`define FWD_ADDR_SIMPLE_STOP 16'h1008

`define FWD_RST_TIMEOUT 16'h0000
`define FWD_RST_MASK 16'h0000
`define FWD_RST_TRIGGER 16'h0000
`define FWD_RST_MIN_REM 16'hFFFF
`define FWD_RST_STOP_SEQ 16'h0000
`define FWD_RST_RESTART 16'h0001
`define FWD_RST_SIMPLE_STOP 16'h0000

`define FWD_STATE_IDLE 2'h0
`define FWD_STATE_RUN 2'h1
`define FWD_STATE_EXP 2'h2

`define FWD_STOP_FIRST 16'hAAAA
`define FWD_STOP_SECOND 16'h5555
`define FWD_SIMPLE_A 16'hAA55
`define FWD_SIMPLE_B 16'h55AA
`define FWD_RESTART_CMD 16'h0001

`define FWD_CODE_MAX 8'h20

`define FWD_TICK_MS 100
`define FWD_CLK_KHZ 20000
`define FWD_TICK_CYCLES (`FWD_TICK_MS * `FWD_CLK_KHZ)

`endif

// ### sim/fwd_master.sv
// Fieldbus master model driving register and request ports
`timescale 1ns/1ns
module fwd_master (
  input wire sys_clk,
  input wire [15:0] rd_data,
  input wire rd_ack,
  output reg reg_wr,
  output reg reg_rd,
  output reg [15:0] reg_addr,
  output reg [15:0] reg_wdata,
  output reg req_valid,
  output reg [7:0] req_code
);
  initial begin
    {reg_wr, reg_rd, req_valid} = 3'h0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    req_code = 8'h00;
  end
  task wr(input [15:0] a, input [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    reg_wdata <= ~d; // Idle data never repeats the last word
  endtask
  task rd(input [15:0] a, output [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(posedge sys_clk);
    d = (rd_ack === 1'h1) ? rd_data : 16'hXXXX;
  endtask
  task req(input [7:0] c);
    @(posedge sys_clk);
    req_valid <= 1'h1;
    req_code <= c;
    @(posedge sys_clk);
    req_valid <= 1'h0;
    req_code <= ~c;
  endtask
  // Both stop words in order, back to back
  task stop_seq;
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= 16'h1005;
    reg_wdata <= 16'hAAAA;
    @(posedge sys_clk);
    reg_wdata <= 16'h5555;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
endmodule

// ### sim/fwd_watchdog_monitor.sv
// Checker of fieldbus watchdog port behaviour
`timescale 1ns/1ns
module fwd_watchdog_monitor (
  input logic sys_clk,
  input logic nrst,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic [15:0] rd_data,
  input logic rd_ack,
  input logic run_state,
  input logic wd_expired,
  input logic wd_fault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire idle = !run_state && !wd_expired;
  wire [15:0] wa = reg_wr ? reg_addr : 16'h0000;
  wire simple = wa == 16'h1008 && (reg_wdata == 16'hAA55 || reg_wdata == 16'h55AA);
  sequence s_arm; wa == 16'h1005 && reg_wdata == 16'hAAAA; endsequence
  sequence s_fin; wa == 16'h1005 && reg_wdata == 16'h5555; endsequence
  AST_STATUS_READ: assert property (reg_rd && !reg_wr && reg_addr == 16'h1006 |=>
    rd_ack && rd_data == {14'h0000, $past(wd_expired), $past(run_state)})
    else $error("status read wrong");
  AST_ONE_STATE: assert property (!(run_state && wd_expired))
    else $error("running and expired together");
  AST_SEQ_STOP: assert property (s_arm ##1 s_fin |=> idle)
    else $error("stop sequence did not stop");
  AST_SIMPLE_STOP: assert property (simple |=> idle && !wd_fault)
    else $error("simple stop failed");
  AST_FAULT_HOLD: assert property (wd_fault && !simple |=> wd_fault)
    else $error("fault dropped");
  AST_EXPIRE: assert property ($rose(wd_expired) |-> wd_fault && $past(run_state))
    else $error("bad expiry");
  AST_IDLE_STAYS: assert property (idle && wa != 16'h1003 |=> idle)
    else $error("left idle without trigger");
  AST_RELOAD: assert property (run_state && reg_wdata != 16'h0000 &&
    (wa == 16'h1003 || wa == 16'h1007 && reg_wdata == 16'h0001) |=> run_state)
    else $error("reload did not keep running");
endmodule
bind fwd_watchdog fwd_watchdog_monitor i_fwd_watchdog_monitor (.sys_clk, .nrst, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .rd_data, .rd_ack, .run_state, .wd_expired, .wd_fault);

// ### sim/fwd_watchdog_tb.sv
// Self-checking bench of the fieldbus watchdog
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module fwd_watchdog_tb;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  wire reg_wr, reg_rd, req_valid, rd_ack, run_state, wd_expired, wd_fault;
  wire [15:0] reg_addr, reg_wdata, rd_data;
  wire [7:0] req_code;
  logic [15:0] d;
  logic [15:0] k = 16'h0010;
  int num_errors = 0;
  int total_checks = 0;
  initial forever #25 sys_clk = ~sys_clk;
  fwd_master i_fwd_master (.sys_clk, .rd_data, .rd_ack, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .req_valid, .req_code);
  // Short tick keeps expiry within a few dozen cycles
  fwd_watchdog #(.TICK_CYCLES(4)) i_fwd_watchdog (.sys_clk, .nrst, .clk_en(1'h1), .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .req_valid, .req_code, .rd_data, .rd_ack, .run_state,
    .wd_expired, .wd_fault);
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task rchk(input [15:0] a, input [15:0] w);
    i_fwd_master.rd(a, d);
    `CHK(d, w)
  endtask
  task t_reset;
    rchk(16'h1003, 16'h0000);
    rchk(16'h1004, 16'hFFFF);
    rchk(16'h1006, 16'h0000);
    rchk(16'h1010, 16'h0000);
    i_fwd_master.wr(16'h1003, 16'h0001);
    rchk(16'h1006, 16'h0000);
  endtask
  task t_expire;
    i_fwd_master.wr(16'h1000, 16'h0003);
    i_fwd_master.wr(16'h1003, 16'h0002);
    cyc(11);
    @(negedge sys_clk) `CHK(run_state, 1'h1)
    @(negedge sys_clk) `CHK(wd_expired, 1'h1)
    `CHK(wd_fault, 1'h1)
    rchk(16'h1006, 16'h0002);
    rchk(16'h1004, 16'h0000);
    i_fwd_master.wr(16'h1000, 16'h0007);
    rchk(16'h1000, 16'h0003);
  endtask
  task t_simple;
    i_fwd_master.wr(16'h1008, 16'hAA55);
    @(negedge sys_clk) `CHK(wd_fault, 1'h0)
    rchk(16'h1006, 16'h0000);
    i_fwd_master.wr(16'h1000, 16'h0002);
    rchk(16'h1000, 16'h0002);
    i_fwd_master.wr(16'h1003, 16'h0003);
    i_fwd_master.wr(16'h1008, 16'h55AA);
    rchk(16'h1006, 16'h0000);
    i_fwd_master.wr(16'h1001, 16'h0010);
  endtask
  // Reload lands before the first expiry would strike; the check falls after it
  task t_reload(input [15:0] a, input [15:0] v);
    k = k + 16'h0001;
    i_fwd_master.wr(16'h1003, k);
    cyc(4);
    if (a == 16'h0000) i_fwd_master.req(8'h05);
    else i_fwd_master.wr(a, v);
    cyc(6);
    @(negedge sys_clk) `CHK(run_state, 1'h1)
    i_fwd_master.wr(16'h1008, 16'hAA55);
  endtask
  task t_seq;
    i_fwd_master.wr(16'h1003, 16'h0100);
    i_fwd_master.stop_seq;
    @(negedge sys_clk) `CHK(run_state, 1'h0)
    i_fwd_master.wr(16'h1007, 16'h0001);
    rchk(16'h1006, 16'h0000);
  endtask
  task final_report;
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(5000);
    num_errors++;
    final_report;
  end
  initial begin
    cyc(3);
    nrst <= 1'h1;
    t_reset;
    t_expire;
    t_simple;
    t_reload(16'h0000, 16'h0000);
    t_reload(16'h1007, 16'h0001);
    t_reload(16'h1003, 16'h7777);
    t_seq;
    final_report;
  end
endmodule
